// >>> logic/sbp_pkg.sv
// Operation
// - Host sends five bytes: period low, period high, duty low, duty high, mode.
// - Period is counter clock divided by sixteen-bit divisor, high byte above low.
// - Output stays high for the duty count of counter clocks each period.
// - Fifth byte goes to the control register; 10011 fast clock, 10001 slow clock.
// - A slow 32 kHz counter clock serves output rates below 256 Hz.
// - Single variable-resolution mode; both period and pulse length programmable.
// - Output frequencies 100 Hz to 200 kHz, duty from 1 to 100 percent.
// - Same waveform drives both sub and main display enables.
package sbp_pkg;

	// ----------------------------------------
	// Clock rates and counter clock increments
	// ----------------------------------------
	localparam longint SYS_CLK_HZ = 250000000;
	localparam longint FAST_CLK_HZ = 16777612;
	localparam longint SLOW_CLK_HZ = 32000;
	localparam int PHASE_W = 32;
	localparam logic [PHASE_W-1:0] FAST_INC =
		PHASE_W'((FAST_CLK_HZ * (64'd1 << PHASE_W)) / SYS_CLK_HZ);
	localparam logic [PHASE_W-1:0] SLOW_INC =
		PHASE_W'((SLOW_CLK_HZ * (64'd1 << PHASE_W)) / SYS_CLK_HZ);

	// ----------------------------------------
	// Configuration stream
	// ----------------------------------------
	localparam int BYTE_W = 8;
	localparam logic [2:0] LAST_BYTE_IDX = 3'h4;
	localparam logic [2:0] LAST_BIT_IDX = 3'h7;

	// ----------------------------------------
	// Control register fields and reset values
	// ----------------------------------------
	localparam int CLK_SEL_BIT = 1;
	localparam logic [7:0] MODE_FAST = 8'h13;
	localparam logic [7:0] MODE_SLOW = 8'h11;
	localparam logic [7:0] CTRL_RST = MODE_FAST;
	localparam logic [15:0] PERIOD_RST = 16'hFFFF;
	localparam logic [15:0] DUTY_RST = 16'h0000;

	// ----------------------------------------
	// Bus register map (byte addresses)
	// ----------------------------------------
	localparam int ADDR_W = 4;
	localparam logic [3:0] OFS_PERIOD = 4'h0;
	localparam logic [3:0] OFS_DUTY = 4'h4;
	localparam logic [3:0] OFS_STATUS = 4'h8;
	localparam logic [3:0] OFS_SW_CTRL = 4'hC;
	localparam int SW_EN_BIT = 0;
	localparam int SW_RESYNC_BIT = 1;
	localparam logic SW_EN_RST = 1'b1;
	localparam int STAT_IDX_LSB = 8;

endpackage

// >>> logic/sbp_sync2.sv
`timescale 1ns/1ns
`default_nettype none
module sbp_sync2 (
	input wire logic i_clock,
	input wire logic i_reset,
	input wire logic i_async,
	input wire logic i_rst_val,
	output logic o_sync
);
	logic meta_reg;
	logic sync_reg;

	// ----------------------------------------
	// Two flip-flop synchroniser
	// ----------------------------------------
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			meta_reg <= i_rst_val;
			sync_reg <= i_rst_val;
		end else begin
			meta_reg <= i_async;
			sync_reg <= meta_reg;
		end
	end

	assign o_sync = sync_reg;
endmodule // sbp_sync2
`default_nettype wire

// >>> logic/sbp_backlight_pwm.sv
// The register addresses and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module sbp_backlight_pwm (
	input wire logic i_clock,
	input wire logic i_reset,
	input wire logic i_spi_sclk,
	input wire logic i_spi_mosi,
	input wire logic i_spi_ss_n,
	input wire logic [sbp_pkg::ADDR_W-1:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	output logic o_sub_display_enable,
	output logic o_main_display_enable
);
	import sbp_pkg::*;

	logic sclk_s;
	logic mosi_s;
	logic ss_n_s;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	sbp_sync2 u_sync_sclk (
		.i_clock(i_clock),
		.i_reset(i_reset),
		.i_async(i_spi_sclk),
		.i_rst_val(1'b0),
		.o_sync(sclk_s)
	);
	sbp_sync2 u_sync_mosi (
		.i_clock(i_clock),
		.i_reset(i_reset),
		.i_async(i_spi_mosi),
		.i_rst_val(1'b0),
		.o_sync(mosi_s)
	);
	sbp_sync2 u_sync_ss (
		.i_clock(i_clock),
		.i_reset(i_reset),
		.i_async(i_spi_ss_n),
		.i_rst_val(1'b1),
		.o_sync(ss_n_s)
	);

	// ----------------------------------------
	// Counter clock enables
	// ----------------------------------------
	logic [PHASE_W-1:0] fast_acc_reg, fast_acc_next;
	logic [PHASE_W-1:0] slow_acc_reg, slow_acc_next;
	logic fast_tick, slow_tick, tick;
	logic [7:0] ctrl_reg, ctrl_next;

	always_comb begin
		{fast_tick, fast_acc_next} = {1'b0, fast_acc_reg} + {1'b0, FAST_INC};
		{slow_tick, slow_acc_next} = {1'b0, slow_acc_reg} + {1'b0, SLOW_INC};
		tick = ctrl_reg[CLK_SEL_BIT] ? fast_tick : slow_tick;
	end

	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			fast_acc_reg <= '0;
			slow_acc_reg <= '0;
		end else begin
			fast_acc_reg <= fast_acc_next;
			slow_acc_reg <= slow_acc_next;
		end
	end

	// ----------------------------------------
	// Serial byte receiver
	// ----------------------------------------
	logic sclk_d_reg, sclk_d_next;
	logic [7:0] shift_reg, shift_next;
	logic [2:0] bit_idx_reg, bit_idx_next;
	logic [2:0] byte_idx_reg, byte_idx_next;
	logic [7:0] shadow_reg [0:3];
	logic [7:0] shadow_next [0:3];
	logic [7:0] shifted;
	logic commit;
	logic resync;

	always_comb begin
		sclk_d_next = sclk_s;
		shift_next = shift_reg;
		bit_idx_next = bit_idx_reg;
		byte_idx_next = byte_idx_reg;
		shadow_next = shadow_reg;
		commit = 1'b0;
		shifted = {shift_reg[6:0], mosi_s};
		if (ss_n_s) begin
			bit_idx_next = '0;
		end else if (sclk_s && !sclk_d_reg) begin
			shift_next = shifted;
			bit_idx_next = bit_idx_reg + 3'h1;
			if (bit_idx_reg == LAST_BIT_IDX) begin
				if (byte_idx_reg == LAST_BYTE_IDX) begin
					commit = 1'b1;
					byte_idx_next = '0;
				end else begin
					shadow_next[byte_idx_reg[1:0]] = shifted;
					byte_idx_next = byte_idx_reg + 3'h1;
				end
			end
		end
		if (resync) begin
			byte_idx_next = '0;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			sclk_d_reg <= 1'b0;
			shift_reg <= '0;
			bit_idx_reg <= '0;
			byte_idx_reg <= '0;
			for (int i = 0; i < 4; i++) begin
				shadow_reg[i] <= '0;
			end
		end else begin
			sclk_d_reg <= sclk_d_next;
			shift_reg <= shift_next;
			bit_idx_reg <= bit_idx_next;
			byte_idx_reg <= byte_idx_next;
			shadow_reg <= shadow_next;
		end
	end

	// ----------------------------------------
	// Active settings and period counter
	// ----------------------------------------
	logic [15:0] period_reg, period_next;
	logic [15:0] duty_reg, duty_next;
	logic [15:0] cnt_reg, cnt_next;
	logic pwm_reg, pwm_next;
	logic sw_en_reg, sw_en_next;
	logic [15:0] last_cnt;

	always_comb begin
		period_next = period_reg;
		duty_next = duty_reg;
		ctrl_next = ctrl_reg;
		cnt_next = cnt_reg;
		last_cnt = period_reg - 16'h0001;
		if (commit) begin
			period_next = {shadow_reg[1], shadow_reg[0]};
			duty_next = {shadow_reg[3], shadow_reg[2]};
			ctrl_next = shifted;
			cnt_next = '0;
		end else if (tick) begin
			cnt_next = (cnt_reg == last_cnt) ? 16'h0000 : cnt_reg + 16'h0001;
		end
		pwm_next = sw_en_reg && (cnt_reg < duty_reg);
	end

	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			period_reg <= PERIOD_RST;
			duty_reg <= DUTY_RST;
			ctrl_reg <= CTRL_RST;
			cnt_reg <= '0;
			pwm_reg <= 1'b0;
		end else begin
			period_reg <= period_next;
			duty_reg <= duty_next;
			ctrl_reg <= ctrl_next;
			cnt_reg <= cnt_next;
			pwm_reg <= pwm_next;
		end
	end

	assign o_sub_display_enable = pwm_reg;
	assign o_main_display_enable = pwm_reg;

	// ----------------------------------------
	// Avalon-MM slave
	// ----------------------------------------
	logic ack_reg, ack_next;
	logic [31:0] rdata_reg, rdata_next;
	logic req;
	logic wr_sw_ctrl;

	always_comb begin
		req = i_avs_read || i_avs_write;
		ack_next = req && !ack_reg;
		rdata_next = rdata_reg;
		wr_sw_ctrl = ack_reg && i_avs_write && (i_avs_address == OFS_SW_CTRL)
			&& i_avs_byteenable[0];
		sw_en_next = wr_sw_ctrl ? i_avs_writedata[SW_EN_BIT] : sw_en_reg;
		resync = wr_sw_ctrl && i_avs_writedata[SW_RESYNC_BIT];
		if (i_avs_read && !ack_reg) begin
			case (i_avs_address)
				OFS_PERIOD: rdata_next = {16'h0000, period_reg};
				OFS_DUTY: rdata_next = {16'h0000, duty_reg};
				OFS_STATUS: rdata_next = {21'h000000, byte_idx_reg, ctrl_reg};
				OFS_SW_CTRL: rdata_next = {31'h00000000, sw_en_reg};
				default: rdata_next = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			ack_reg <= 1'b0;
			rdata_reg <= '0;
			sw_en_reg <= SW_EN_RST;
		end else begin
			ack_reg <= ack_next;
			rdata_reg <= rdata_next;
			sw_en_reg <= sw_en_next;
		end
	end

	assign o_avs_waitrequest = req && !ack_reg;
	assign o_avs_readdata = rdata_reg;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_reset);

	logic [15:0] sh_period, sh_duty;
	assign sh_period = {shadow_reg[1], shadow_reg[0]};
	assign sh_duty = {shadow_reg[3], shadow_reg[2]};

	sequence commit_s;
		commit;
	endsequence
	sequence wrap_s;
		!commit && tick && (cnt_reg == last_cnt);
	endsequence

	load_period_order_a: assert property (commit_s |=>
		period_reg == $past(sh_period) && duty_reg == $past(sh_duty))
		else $error("period or duty not loaded from bytes one to four");
	period_wrap_a: assert property (wrap_s |=> cnt_reg == 16'h0000)
		else $error("period counter did not wrap at divisor");
	duty_level_a: assert property (sw_en_reg && !commit && cnt_reg < duty_reg
		|=> pwm_reg)
		else $error("output low inside duty count");
	duty_low_a: assert property (cnt_reg >= duty_reg ##1 1'b1 |-> !pwm_reg)
		else $error("output high past duty count");
	ctrl_copy_a: assert property (commit_s |=> ctrl_reg == $past(shifted))
		else $error("mode byte not copied to control register");
	slow_rate_a: assert property (slow_tick |=> !slow_tick [*7])
		else $error("slow counter clock too fast");
	fast_rate_a: assert property (fast_tick |=> !fast_tick [*8])
		else $error("fast counter clock too fast");
	count_hold_a: assert property (!tick && !commit |=> $stable(cnt_reg))
		else $error("period counter moved without a counter clock");
	both_outputs_a: assert property (o_sub_display_enable == o_main_display_enable)
		else $error("display enables differ");
	no_early_load_a: assert property (!commit |=> $stable(period_reg) && $stable(duty_reg))
		else $error("settings changed before mode byte");

	// ----------------------------------------
	// Receiver, counter and output enable assertions
	// ----------------------------------------
	sequence sclk_rise_s;
		!ss_n_s && sclk_s && !sclk_d_reg;
	endsequence
	sequence byte_done_s;
		!ss_n_s && sclk_s && !sclk_d_reg && (bit_idx_reg == LAST_BIT_IDX);
	endsequence

	select_clear_a: assert property (ss_n_s |=> bit_idx_reg == 3'h0)
		else $error("bit counter kept while select high");
	bit_step_a: assert property (sclk_rise_s |=>
		bit_idx_reg == $past(bit_idx_reg) + 3'h1)
		else $error("bit counter did not step on serial clock");
	msb_first_a: assert property (sclk_rise_s |=>
		shift_reg == {$past(shift_reg[6:0]), $past(mosi_s)})
		else $error("serial data not shifted msb first");
	bit_idle_a: assert property (!ss_n_s && !(sclk_s && !sclk_d_reg)
		|=> $stable(bit_idx_reg))
		else $error("bit counter moved without a serial clock edge");
	byte_step_a: assert property (byte_done_s ##0 (!resync && byte_idx_reg != LAST_BYTE_IDX)
		|=> byte_idx_reg == $past(byte_idx_reg) + 3'h1)
		else $error("byte index did not advance after a byte");
	byte_range_a: assert property (byte_idx_reg <= LAST_BYTE_IDX)
		else $error("byte index beyond mode byte");
	commit_only_a: assert property (commit |-> byte_done_s ##0 (byte_idx_reg == LAST_BYTE_IDX))
		else $error("settings loaded before fifth byte");
	commit_clear_a: assert property (commit_s |=> byte_idx_reg == 3'h0)
		else $error("byte index not restarted after mode byte");
	count_range_a: assert property (cnt_reg <= last_cnt)
		else $error("period counter beyond divisor");
	count_step_a: assert property (tick && !commit && cnt_reg != last_cnt
		|=> cnt_reg == $past(cnt_reg) + 16'h0001)
		else $error("period counter did not step on counter clock");
	slow_select_a: assert property (!ctrl_reg[CLK_SEL_BIT] && !slow_tick && !commit
		|=> $stable(cnt_reg))
		else $error("fast counter clock used in slow mode");
	fast_select_a: assert property (ctrl_reg[CLK_SEL_BIT] && !fast_tick && !commit
		|=> $stable(cnt_reg))
		else $error("slow counter clock used in fast mode");
	fast_period_a: assert property (fast_tick |-> ##[1:16] fast_tick)
		else $error("fast counter clock too slow");
	enable_off_a: assert property (!sw_en_reg |=> !pwm_reg)
		else $error("display enables high while output disabled");
	commit_start_a: assert property (commit_s |=> cnt_reg == 16'h0000)
		else $error("period counter not restarted by new settings");
endmodule // sbp_backlight_pwm
`default_nettype wire

// >>> sim/sbp_spi_host.sv
`timescale 1ns/1ns
`default_nettype none
module sbp_spi_host (
	input wire logic i_clock,
	output logic o_sclk,
	output logic o_mosi,
	output logic o_ss_n
);
	// ----------------------------------------
	// Idle levels: clock still, select high
	// ----------------------------------------
	initial begin
		o_sclk = 1'b0;
		o_mosi = 1'b0;
		o_ss_n = 1'b1;
	end

	// ----------------------------------------
	// One byte, MSB first, under low select
	// ----------------------------------------
	task automatic send(input logic [7:0] b);
		o_ss_n <= 1'b0;
		for (int i = 7; i >= 0; i--) begin
			o_mosi <= b[i];
			repeat (4) @(posedge i_clock);
			o_sclk <= 1'b1;
			repeat (4) @(posedge i_clock);
			o_sclk <= 1'b0;
		end
		repeat (4) @(posedge i_clock);
		o_ss_n <= 1'b1;
		o_mosi <= ~b[0];
		repeat (4) @(posedge i_clock);
	endtask
endmodule // sbp_spi_host
`default_nettype wire

// >>> sim/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
	import sbp_pkg::*;
	logic i_clock = 1'b0;
	logic i_reset = 1'b1;
	logic [3:0] addr = 4'h0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata;
	logic [31:0] q;
	logic waitreq, sub_en, main_en, sclk, mosi, ss_n;
	int n_mismatch = 0;
	int compares = 0;
	int hi, lo, c;

	always #2 i_clock = ~i_clock;

	sbp_spi_host host (.i_clock(i_clock), .o_sclk(sclk), .o_mosi(mosi), .o_ss_n(ss_n));
	sbp_backlight_pwm uut (.i_clock(i_clock), .i_reset(i_reset), .i_spi_sclk(sclk),
		.i_spi_mosi(mosi), .i_spi_ss_n(ss_n), .i_avs_address(addr), .i_avs_read(rd),
		.i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(4'hF),
		.o_avs_readdata(rdata), .o_avs_waitrequest(waitreq),
		.o_sub_display_enable(sub_en), .o_main_display_enable(main_en));

	// ----------------------------------------
	// Checking and closing
	// ----------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %0t seen %h want %h", $time, seen, exp);
		end
	endtask

	task automatic give_verdict();
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	function automatic logic [31:0] near(longint a, longint e);
		return (a > e - 16 && a < e + 16) ? 32'h1 : 32'h0;
	endfunction

	always @(posedge i_clock) begin
		if (!i_reset)
			check(main_en, sub_en);
	end

	// ----------------------------------------
	// Bus and stimulus tasks
	// ----------------------------------------
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		addr <= a;
		wdata <= d;
		rd <= ~w;
		wr <= w;
		do begin
			@(posedge i_clock);
			n++;
		end while (waitreq !== 1'b0 && n < 20);
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		if (n >= 20) begin
			check(32'h0, 32'h1);
			give_verdict();
		end
		@(posedge i_clock);
	endtask

	task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		check(q, exp);
	endtask

	task automatic cfg(input logic [39:0] v, input int nb);
		for (int i = 0; i < nb; i++)
			host.send(v[39 - 8 * i -: 8]);
	endtask

	task automatic run(input logic lvl, output int len);
		len = 0;
		while (sub_en === lvl && len < 40000) begin
			@(posedge i_clock);
			len++;
		end
		if (len >= 40000) begin
			check(32'h0, 32'h1);
			give_verdict();
		end
	endtask

	task automatic measure(input longint d, input longint p, input longint hz);
		run(1'b1, c);
		run(1'b0, c);
		run(1'b1, hi);
		run(1'b0, lo);
		check(near(hi, d * SYS_CLK_HZ / hz), 32'h1);
		check(near(hi + lo, p * SYS_CLK_HZ / hz), 32'h1);
	endtask

	task automatic count_high(input int n, output int cnt);
		cnt = 0;
		repeat (n) begin
			@(posedge i_clock);
			if (sub_en === 1'b1)
				cnt++;
		end
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (10) @(posedge i_clock);
		i_reset <= 1'b0;
		repeat (4) @(posedge i_clock);
		rd_chk(OFS_PERIOD, 32'h0000FFFF);
		rd_chk(OFS_DUTY, 32'h00000000);
		rd_chk(OFS_STATUS, {24'h0, MODE_FAST});
		rd_chk(OFS_SW_CTRL, 32'h00000001);
		rd_chk(4'h2, 32'h00000000);
		bus(1'b1, OFS_PERIOD, 32'h00001234);
		rd_chk(OFS_PERIOD, 32'h0000FFFF);
		cfg(40'hA8_00_86_00_13, 4);
		rd_chk(OFS_PERIOD, 32'h0000FFFF);
		rd_chk(OFS_STATUS, 32'h00000413);
		host.send(MODE_FAST);
		rd_chk(OFS_PERIOD, 32'h000000A8);
		rd_chk(OFS_DUTY, 32'h00000086);
		rd_chk(OFS_STATUS, {24'h0, MODE_FAST});
		measure(134, 168, FAST_CLK_HZ);
		cfg(40'h55_55_00_00_00, 2);
		rd_chk(OFS_STATUS, 32'h00000213);
		bus(1'b1, OFS_SW_CTRL, 32'h00000003);
		rd_chk(OFS_STATUS, {24'h0, MODE_FAST});
		rd_chk(OFS_SW_CTRL, 32'h00000001);
		bus(1'b1, OFS_SW_CTRL, 32'h00000000);
		count_high(300, c);
		check(c, 32'd0);
		bus(1'b1, OFS_SW_CTRL, 32'h00000001);
		cfg(40'h0A_00_0A_00_13, 5);
		count_high(400, c);
		check(c, 32'd400);
		cfg(40'h03_00_02_00_11, 5);
		rd_chk(OFS_STATUS, {24'h0, MODE_SLOW});
		measure(2, 3, SLOW_CLK_HZ);
		give_verdict();
	end
endmodule // tb
`default_nettype wire
